// >>> hw/ufs_busy.sv
// Busy indication with an optional settle delay standing in for a slower serial clock.
`timescale 1ns/100ps
`include "ufs_regs.svh"
module ufs_busy
  import ufs_pkg::*;
#(
  parameter int DELAY = `UFS_BUSY_DELAY
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic slow_tick,
  input  wire logic active,
  output logic      busy
);
  // The tick counter is 8 bits wide.
  if (DELAY < 0 || DELAY > 255)
    $error("ufs_busy: DELAY out of range");

  typedef struct packed {
    ufs_busy_st_t state;
    logic [7:0]   cnt;
  } ufs_busy_reg_t;

  ufs_busy_reg_t st;
  ufs_busy_reg_t next_st;

  // Rising busy waits DELAY slow ticks; falling busy is immediate so software never
  // sees a stale busy after the transfer ends.
  always_comb
  begin
    next_st = st;
    case (st.state)
      UFS_IDLE:
      begin
        if (active)
        begin
          next_st.cnt = 8'h00;
          next_st.state = (DELAY == 0) ? UFS_ACTIVE : UFS_DELAY;
        end
      end
      UFS_DELAY:
      begin
        if (!active)
          next_st.state = UFS_IDLE;
        else if (slow_tick)
        begin
          next_st.cnt = st.cnt + 8'h01;
          if (st.cnt + 8'h01 >= DELAY[7:0])
            next_st.state = UFS_ACTIVE;
        end
      end
      UFS_ACTIVE:
      begin
        if (!active)
          next_st.state = UFS_IDLE;
      end
      default:
        next_st.state = UFS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '{state: UFS_IDLE, cnt: 8'h00};
    else
      st <= next_st;
  end

  assign busy = (st.state == UFS_ACTIVE);
endmodule

// >>> hw/ufs_level.sv
// Occupancy counter and full/empty flags for one queue.
`timescale 1ns/100ps
`include "ufs_regs.svh"
module ufs_level
  import ufs_pkg::*;
#(
  parameter int DEPTH = `UFS_DEPTH
)
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    clear,
  input  wire logic                    push,
  input  wire logic                    pop,
  output logic [`UFS_LEVEL_W-1:0]      level,
  output logic                         full,
  output logic                         empty
);
  localparam logic [`UFS_LEVEL_W-1:0] DEPTH_L = DEPTH[`UFS_LEVEL_W-1:0];

  // The level register is 16 bits wide, so deeper queues cannot be reported.
  if (DEPTH < 1 || DEPTH > 65535)
    $error("ufs_level: DEPTH out of range");

  typedef struct packed {
    logic [`UFS_LEVEL_W-1:0] level;
    logic                    full;
    logic                    empty;
  } ufs_level_st_t;

  ufs_level_st_t st;
  ufs_level_st_t next_st;

  // Flags are derived from the next count so they move with it in one edge.
  always_comb
  begin
    logic do_push;
    logic do_pop;
    next_st = st;
    do_push = push && !st.full;
    do_pop  = pop && !st.empty;
    if (clear)
      next_st.level = '0;
    else if (do_push && !do_pop)
      next_st.level = st.level + 16'h0001;
    else if (do_pop && !do_push)
      next_st.level = st.level - 16'h0001;
    next_st.full  = (next_st.level == DEPTH_L);
    next_st.empty = (next_st.level == 16'h0000);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '{level: `UFS_LEVEL_RESET, full: 1'b0, empty: 1'b1};
    else
      st <= next_st;
  end

  assign level = st.level;
  assign full  = st.full;
  assign empty = st.empty;
endmodule

// >>> hw/ufs_pkg.sv
// Types shared by the FIFO status block.
package ufs_pkg;
  typedef enum logic [1:0] {
    UFS_IDLE   = 2'h0,
    UFS_DELAY  = 2'h1,
    UFS_ACTIVE = 2'h3
  } ufs_busy_st_t;
endpackage

// >>> hw/ufs_regs.svh
// Register offsets, field positions, reset values and timing counts of the FIFO status block.
// Contract
// - The receive-full bit 4 is high only while every receive queue entry is taken and resets to 0.
// - The receive-not-empty bit 3 is high whenever the receive queue holds at least one entry.
// - The transmit-empty bit 2 is high while the transmit queue holds nothing and resets to 1.
// - The transmit-not-full bit 1 is high while the transmit queue has room and resets to 1.
// - The busy bit 0 is high while a serial transfer is active and resets to 0.
// - Busy may stay low while a start bit is still arriving with both holding buffers empty.
// - With a slower serial clock, busy may rise several slow cycles after activity begins.
// - The transmit level register reads the transmit queue occupancy in bits 15 to 0, zero after reset.
// - The receive level register reads the receive queue occupancy in bits 15 to 0, zero after reset.
`ifndef UFS_REGS_SVH
`define UFS_REGS_SVH
`define UFS_ADDR_W          32
`define UFS_DATA_W          32
`define UFS_SERIAL_STATUS   32'h5000117C
`define UFS_TX_QUEUE_LEVEL  32'h50001180
`define UFS_RX_QUEUE_LEVEL  32'h50001184
`define UFS_BIT_RX_FULL     4
`define UFS_BIT_RX_NEMPTY   3
`define UFS_BIT_TX_EMPTY    2
`define UFS_BIT_TX_NFULL    1
`define UFS_BIT_BUSY        0
`define UFS_LEVEL_W         16
`define UFS_STATUS_RESET    16'h0006
`define UFS_LEVEL_RESET     16'h0000
`define UFS_DEPTH           16
`define UFS_BUSY_DELAY      3
`endif

// >>> hw/ufs_top.sv
// Register front end of the serial FIFO status block.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "ufs_regs.svh"
module ufs_top
  import ufs_pkg::*;
#(
  parameter int TX_DEPTH   = `UFS_DEPTH,
  parameter int RX_DEPTH   = `UFS_DEPTH,
  parameter int BUSY_DELAY = `UFS_BUSY_DELAY
)
(
  input  wire logic                   CLK,
  input  wire logic                   ARST_N,
  input  wire logic [`UFS_ADDR_W-1:0] ADDR,
  input  wire logic [`UFS_DATA_W-1:0] WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic [`UFS_DATA_W-1:0]      RDATA,
  input  wire logic                   TX_PUSH,
  input  wire logic                   TX_POP,
  input  wire logic                   TX_CLEAR,
  input  wire logic                   RX_PUSH,
  input  wire logic                   RX_POP,
  input  wire logic                   RX_CLEAR,
  input  wire logic                   TX_SHIFTING,
  input  wire logic                   RX_CHAR_ACTIVE,
  input  wire logic                   SLOW_TICK,
  output logic                        TX_QUEUE_FULL,
  output logic                        RX_QUEUE_NOT_EMPTY
);
  logic [`UFS_LEVEL_W-1:0] tx_level;
  logic [`UFS_LEVEL_W-1:0] rx_level;
  logic                    tx_full;
  logic                    tx_empty;
  logic                    rx_full;
  logic                    rx_empty;
  logic                    busy;
  logic                    active;

  ufs_level #(.DEPTH(TX_DEPTH)) u_tx
  (
    .clk    (CLK),
    .arst_n (ARST_N),
    .clear  (TX_CLEAR),
    .push   (TX_PUSH),
    .pop    (TX_POP),
    .level  (tx_level),
    .full   (tx_full),
    .empty  (tx_empty)
  );

  ufs_level #(.DEPTH(RX_DEPTH)) u_rx
  (
    .clk    (CLK),
    .arst_n (ARST_N),
    .clear  (RX_CLEAR),
    .push   (RX_PUSH),
    .pop    (RX_POP),
    .level  (rx_level),
    .full   (rx_full),
    .empty  (rx_empty)
  );

  // A receive character only counts once its start bit is qualified at mid-bit, so an
  // arriving start with both holding buffers empty may still read as idle.
  assign active = TX_SHIFTING || RX_CHAR_ACTIVE || !tx_empty;

  ufs_busy #(.DELAY(BUSY_DELAY)) u_busy
  (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .slow_tick (SLOW_TICK),
    .active    (active),
    .busy      (busy)
  );

  typedef struct packed {
    logic [`UFS_DATA_W-1:0] rdata;
  } ufs_top_st_t;

  ufs_top_st_t st;
  ufs_top_st_t next_st;
  logic [`UFS_LEVEL_W-1:0] status;

  always_comb
  begin
    status = '0;
    status[`UFS_BIT_RX_FULL]   = rx_full;
    status[`UFS_BIT_RX_NEMPTY] = !rx_empty;
    status[`UFS_BIT_TX_EMPTY]  = tx_empty;
    status[`UFS_BIT_TX_NFULL]  = !tx_full;
    status[`UFS_BIT_BUSY]      = busy;
  end

  // All registers are read only; writes are accepted and dropped. Unmapped reads give zero.
  always_comb
  begin
    next_st = st;
    if (RD)
    begin
      if (ADDR == `UFS_SERIAL_STATUS)
        next_st.rdata = {16'h0000, status};
      else if (ADDR == `UFS_TX_QUEUE_LEVEL)
        next_st.rdata = {16'h0000, tx_level};
      else if (ADDR == `UFS_RX_QUEUE_LEVEL)
        next_st.rdata = {16'h0000, rx_level};
      else
        next_st.rdata = '0;
    end
    else
      next_st.rdata = '0;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      st <= '{rdata: 32'h00000000};
    else
      st <= next_st;
  end

  assign RDATA              = st.rdata;
  assign TX_QUEUE_FULL      = tx_full;
  assign RX_QUEUE_NOT_EMPTY = !rx_empty;
endmodule

// >>> sim/uart_fifo_status_bench.sv
// Self-checking bench for the FIFO status block.
`timescale 1ns/100ps
`include "ufs_regs.svh"
module uart_fifo_status_bench;
  import ufs_pkg::*;
  localparam int D = 4;
  logic CLK, ARST_N, WR, RD, SLOW_TICK, TX_SHIFTING, RX_CHAR_ACTIVE, bsy;
  logic TX_PUSH, TX_POP, TX_CLEAR, RX_PUSH, RX_POP, RX_CLEAR, TX_QUEUE_FULL, RX_QUEUE_NOT_EMPTY;
  logic [31:0] ADDR, WDATA, RDATA, r;
  int n_errors, check_count, seed, tx, rx, i;
  ufs_top #(.TX_DEPTH(D), .RX_DEPTH(D), .BUSY_DELAY(3)) u_dut (.*);
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Push when full and pop when empty are dropped before they cancel each other,
  // so a full queue with push and pop together still loses one entry; clear wins.
  function automatic int nxt(int l, logic p, q, c);
    if (c)
      return 0;
    if (p && l < D && !(q && l > 0))
      return l + 1;
    if (q && l > 0 && !(p && l < D))
      return l - 1;
    return l;
  endfunction
  task automatic evt(input logic [5:0] e);
    @(posedge CLK);
    {TX_PUSH, TX_POP, TX_CLEAR, RX_PUSH, RX_POP, RX_CLEAR} <= e;
    tx = nxt(tx, e[5], e[4], e[3]);
    rx = nxt(rx, e[2], e[1], e[0]);
  endtask
  task automatic rd(input logic [31:0] a, exp);
    @(posedge CLK);
    {TX_PUSH, TX_POP, TX_CLEAR, RX_PUSH, RX_POP, RX_CLEAR} <= 6'h00;
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("rdata", RDATA, exp);
  endtask
  task automatic rd_all;
    rd(`UFS_SERIAL_STATUS, {27'h0, rx == D, rx != 0, tx == 0, tx != D, bsy});
    rd(`UFS_TX_QUEUE_LEVEL, tx);
    rd(`UFS_RX_QUEUE_LEVEL, rx);
    chk("tx_queue_full", TX_QUEUE_FULL, tx == D);
    chk("rx_queue_not_empty", RX_QUEUE_NOT_EMPTY, rx != 0);
  endtask
  task automatic tick;
    @(posedge CLK);
    SLOW_TICK <= 1'b1;
    @(posedge CLK);
    SLOW_TICK <= 1'b0;
  endtask
  initial
  begin
    seed = 75;
    {ARST_N, WR, RD, SLOW_TICK, TX_SHIFTING, RX_CHAR_ACTIVE, bsy} = 7'h00;
    {TX_PUSH, TX_POP, TX_CLEAR, RX_PUSH, RX_POP, RX_CLEAR} = 6'h00;
    {ADDR, WDATA} = 64'h0;
    repeat (10) @(posedge CLK);
    ARST_N <= 1'b1;
    rd_all;
    rd(32'h50001188, 32'h0);
    @(posedge CLK);
    WR <= 1'b1;
    WDATA <= $random(seed);
    @(posedge CLK);
    WR <= 1'b0;
    rd_all;
    repeat (6) evt(6'h24);
    rd_all;
    repeat (6) evt(6'h12);
    rd_all;
    for (i = 0; i < 300; i++)
    begin
      r = $random(seed);
      evt({r[0] | r[1], r[2], r[7:3] == 0, r[8] | r[9], r[10], r[15:11] == 0});
      if (r[16])
        rd_all;
    end
    evt(6'h09);
    repeat (3) tick;
    rd_all;
    for (i = 0; i < 2; i++)
    begin
      @(posedge CLK);
      {TX_SHIFTING, RX_CHAR_ACTIVE} <= i ? 2'h1 : 2'h2;
      repeat (2) tick;
      rd_all;
      tick;
      bsy = 1'b1;
      rd_all;
      @(posedge CLK);
      {TX_SHIFTING, RX_CHAR_ACTIVE} <= 2'h0;
      bsy = 1'b0;
      rd_all;
    end
    tally_and_finish;
  end
  initial
  begin
    #400000;
    n_errors++;
    tally_and_finish;
  end
endmodule

// >>> sim/ufs_props.sv
// Port assertions for the FIFO status block.
`timescale 1ns/100ps
`include "ufs_regs.svh"
module ufs_props (
  input wire logic                   CLK,
  input wire logic                   ARST_N,
  input wire logic [`UFS_ADDR_W-1:0] ADDR,
  input wire logic                   RD,
  input wire logic [`UFS_DATA_W-1:0] RDATA,
  input wire logic                   TX_PUSH,
  input wire logic                   TX_POP,
  input wire logic                   TX_CLEAR,
  input wire logic                   RX_PUSH,
  input wire logic                   RX_POP,
  input wire logic                   RX_CLEAR,
  input wire logic                   TX_QUEUE_FULL,
  input wire logic                   RX_QUEUE_NOT_EMPTY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("RDATA not idle");
  a_rdata_upper: assert property (RD |=> RDATA[31:16] == 16'h0) else $error("upper bits");
  a_status_map: assert property (RD && ADDR == `UFS_SERIAL_STATUS |=>
    RDATA[3] == $past(RX_QUEUE_NOT_EMPTY) && RDATA[1] == !$past(TX_QUEUE_FULL))
    else $error("status flags");
  a_rx_push: assert property (RX_PUSH && !RX_POP && !RX_CLEAR |=> RX_QUEUE_NOT_EMPTY)
    else $error("rx push");
  a_rx_clear: assert property (RX_CLEAR |=> !RX_QUEUE_NOT_EMPTY) else $error("rx clear");
  a_tx_clear: assert property (TX_CLEAR |=> !TX_QUEUE_FULL) else $error("tx clear");
  a_tx_pop: assert property (TX_POP && !TX_PUSH |=> !TX_QUEUE_FULL) else $error("tx pop");
  a_rx_hold: assert property (!(RX_PUSH || RX_POP || RX_CLEAR) |=>
    $stable(RX_QUEUE_NOT_EMPTY)) else $error("rx flag moved");
  a_full_hold: assert property (TX_QUEUE_FULL && !TX_POP && !TX_CLEAR |=> TX_QUEUE_FULL)
    else $error("full dropped");
  c_full: cover property (TX_QUEUE_FULL);
  c_busy: cover property (RD ##1 RDATA[0]);
  c_rxclr: cover property (RX_QUEUE_NOT_EMPTY ##1 RX_CLEAR);
endmodule
bind ufs_top ufs_props u_props (.CLK, .ARST_N, .ADDR, .RD, .RDATA, .TX_PUSH, .TX_POP,
  .TX_CLEAR, .RX_PUSH, .RX_POP, .RX_CLEAR, .TX_QUEUE_FULL, .RX_QUEUE_NOT_EMPTY);
